// ==== src/spt_defs.vh ====
// Offsets, reset values and field masks of the port tuning register group
`ifndef SPT_DEFS_VH
`define SPT_DEFS_VH

`define SPT_OFS_TL_CTRL      8'h8c
`define SPT_OFS_PHY_LANE_GLB 8'h90
`define SPT_OFS_TX_MARGIN    8'h94
`define SPT_OFS_OPMODE       8'h98

`define SPT_RST_TL_CTRL      32'h0079_1094
`define SPT_RST_TL_RSTSEL_UP 32'h0000_0800
`define SPT_RST_PHY_LANE_GLB 32'h0000_8000
`define SPT_RST_TX_MARGIN    32'h0000_116b
`define SPT_RST_OPMODE_5P    32'h005f_0002
`define SPT_RST_OPMODE_6P    32'h007f_0022

`define SPT_VLD_TL_CTRL      32'hbfff_1fff
`define SPT_VLD_PHY_LANE_GLB 32'hffff_807f
`define SPT_VLD_TX_MARGIN    32'h0000_ffff
`define SPT_VLD_OPMODE       32'h0fff_01ff

`define SPT_HOST_TL_CTRL     32'h0000_0060
`define SPT_EE_ONLY_TL_CTRL  32'h0000_0040
`define SPT_SB_OPMODE        32'h0fff_0000
`define SPT_STRAP_OPMODE     32'h0000_01ff

`define SPT_UP_TL_CTRL       32'h3c00_10ff
`define SPT_UP_PHY_LANE_GLB  32'hffff_8000
`define SPT_UP_TX_MARGIN     32'h0000_ffff
`define SPT_UP_OPMODE        32'h00ff_0000

`define SPT_BIT_ORD_OFF      6
`define SPT_BIT_PORT_OFF     10
`define SPT_BIT_RSTSEL       11
`define SPT_POS_RATE_TRY     8
`define SPT_POS_AUX_PHY      16
`define SPT_POS_DELTA        15
`define SPT_POS_CLKBUF       16

`endif

// ==== src/spt_word.v ====
// One 32-bit tuning word with host, sideband, autoload and strap update paths
`timescale 1ns/10ps
module spt_word #(
	parameter [31:0] RST     = 32'h0000_0000,
	parameter [31:0] VALID   = 32'hffff_ffff,
	parameter [31:0] HOST_M  = 32'h0000_0000,
	parameter [31:0] SB_M    = 32'hffff_ffff,
	parameter [31:0] EE_M    = 32'hffff_ffff,
	parameter [31:0] HW_M    = 32'h0000_0000
) (
	input  wire        clock,
	input  wire        nrst,
	input  wire        host_we,
	input  wire [3:0]  host_be,
	input  wire [31:0] host_d,
	input  wire        sb_we,
	input  wire        sb_eeprom,
	input  wire [31:0] sb_d,
	input  wire        hw_ld,
	input  wire [31:0] hw_d,
	output reg  [31:0] q_ff
);
	reg  [31:0] nxt_q;
	wire [31:0] be_m;
	wire [31:0] hm;
	wire [31:0] sm;

	assign be_m = {{8{host_be[3]}}, {8{host_be[2]}}, {8{host_be[1]}}, {8{host_be[0]}}};
	assign hm   = HOST_M & VALID & be_m;
	assign sm   = (sb_eeprom ? EE_M : SB_M) & VALID;

	always @*
	begin
		nxt_q = q_ff;
		if (hw_ld)
			nxt_q = (nxt_q & ~(HW_M & VALID)) | (hw_d & HW_M & VALID);
		if (host_we)
			nxt_q = (nxt_q & ~hm) | (host_d & hm);
		// Sideband applied last so it wins a same-cycle collision with the host
		if (sb_we)
			nxt_q = (nxt_q & ~sm) | (sb_d & sm);
	end

	always @(posedge clock)
	begin
		if (!nrst)
			q_ff <= RST & VALID;
		else
			q_ff <= nxt_q;
	end
endmodule // spt_word

// ==== src/spt_regs.v ====
// Per-port tuning register group of the packet switch
// Function
// - Sideband SMBus/I2C or EEPROM autoload can overwrite every field default except operation mode strap bits 8:0; bit 6 of 8Ch only from EEPROM.
// - Upstream-only fields take effect from the upstream port's copy.
// - Bit 6 disables relaxed ordering; resets zero; only EEPROM changes default.
// - Bit 10 disables the port when set; resets zero.
// - Bits 9:8 choose rate change attempt count; reset zero.
// - Bits 23:16 reset 79h; low bit one disables PHY error retrain.
// - Bit 11 reset select: one on upstream, zero on downstream.
// - Lane PHY mode in bits 6:0 of word 90h, reset 00h.
// - Global PHY delta bits 31:15 reset 0_0001h, upstream copy only.
// - Operation mode bits 8:0 report straps; bits 15:9 reserved.
// - Operation mode resets 0002h five-port, 0022h six-port.
// - Clock buffer control resets 7Fh six-port, 5Fh five-port.
`timescale 1ns/10ps
`include "spt_defs.vh"
module spt_regs #(
	parameter IS_UPSTREAM = 1,
	parameter SIX_PORT    = 1
) (
	input  wire        clock,
	input  wire        nrst,
	input  wire        cfg_rd,
	input  wire        cfg_wr,
	input  wire [7:0]  cfg_addr,
	input  wire [3:0]  cfg_be,
	input  wire [31:0] cfg_wdata,
	output reg         cfg_ack_ff,
	output reg  [31:0] cfg_rdata_ff,
	input  wire        sb_wr,
	input  wire        sb_eeprom,
	input  wire [7:0]  sb_addr,
	input  wire [31:0] sb_wdata,
	input  wire        sb_load_busy,
	input  wire [8:0]  strap_mode,
	input  wire [31:0] up_tl_ctrl,
	input  wire [31:0] up_phy_lane_glb,
	input  wire [31:0] up_tx_margin,
	input  wire [31:0] up_opmode,
	output reg  [31:0] tl_ctrl_ff,
	output reg  [31:0] phy_lane_glb_ff,
	output reg  [31:0] tx_margin_ff,
	output reg  [31:0] opmode_ff,
	output reg         ordering_rule_off_ff,
	output reg         port_off_ff,
	output reg  [1:0]  rate_change_attempt_count_ff,
	output reg         phy_err_retrain_off_ff,
	output reg         reset_source_sel_ff,
	output reg  [6:0]  lane_phy_mode_ff,
	output reg  [16:0] phy_delta_ff,
	output reg  [15:0] tx_margin_param_ff,
	output reg  [7:0]  clock_buffer_ctrl_ff
);
	localparam [31:0] TL_RST = `SPT_RST_TL_CTRL | (IS_UPSTREAM ? `SPT_RST_TL_RSTSEL_UP : 32'h0000_0000);
	localparam [31:0] OM_RST = SIX_PORT ? `SPT_RST_OPMODE_6P : `SPT_RST_OPMODE_5P;

	wire        take;
	wire        host_we;
	wire [31:0] q_tl;
	wire [31:0] q_phy;
	wire [31:0] q_mrg;
	wire [31:0] q_om;
	wire [31:0] eff_tl;
	wire [31:0] eff_phy;
	wire [31:0] eff_mrg;
	wire [31:0] eff_om;
	wire        we_tl;
	wire        we_phy;
	wire        we_mrg;
	wire        we_om;
	wire        sb_tl;
	wire        sb_phy;
	wire        sb_mrg;
	wire        sb_om;
	reg         strap_done_ff;
	reg  [31:0] nxt_rdata;

	// Host access is held off while sideband or autoload is still filling values
	assign take    = (cfg_rd | cfg_wr) & ~sb_load_busy & ~cfg_ack_ff;
	assign host_we = cfg_wr & take;
	assign we_tl   = host_we & (cfg_addr == `SPT_OFS_TL_CTRL);
	assign we_phy  = host_we & (cfg_addr == `SPT_OFS_PHY_LANE_GLB);
	assign we_mrg  = host_we & (cfg_addr == `SPT_OFS_TX_MARGIN);
	assign we_om   = host_we & (cfg_addr == `SPT_OFS_OPMODE);
	assign sb_tl   = sb_wr & (sb_addr == `SPT_OFS_TL_CTRL);
	assign sb_phy  = sb_wr & (sb_addr == `SPT_OFS_PHY_LANE_GLB);
	assign sb_mrg  = sb_wr & (sb_addr == `SPT_OFS_TX_MARGIN);
	assign sb_om   = sb_wr & (sb_addr == `SPT_OFS_OPMODE);

	spt_word #(
		.RST    (TL_RST),
		.VALID  (`SPT_VLD_TL_CTRL),
		.HOST_M (`SPT_HOST_TL_CTRL),
		.SB_M   (`SPT_VLD_TL_CTRL & ~`SPT_EE_ONLY_TL_CTRL),
		.EE_M   (`SPT_VLD_TL_CTRL),
		.HW_M   (32'h0000_0000)
	) u_tl (
		.clock     (clock),
		.nrst      (nrst),
		.host_we   (we_tl),
		.host_be   (cfg_be),
		.host_d    (cfg_wdata),
		.sb_we     (sb_tl),
		.sb_eeprom (sb_eeprom),
		.sb_d      (sb_wdata),
		.hw_ld     (1'b0),
		.hw_d      (32'h0000_0000),
		.q_ff      (q_tl)
	);

	spt_word #(
		.RST    (`SPT_RST_PHY_LANE_GLB),
		.VALID  (`SPT_VLD_PHY_LANE_GLB),
		.HOST_M (32'h0000_0000),
		.SB_M   (32'hffff_ffff),
		.EE_M   (32'hffff_ffff),
		.HW_M   (32'h0000_0000)
	) u_phy (
		.clock     (clock),
		.nrst      (nrst),
		.host_we   (we_phy),
		.host_be   (cfg_be),
		.host_d    (cfg_wdata),
		.sb_we     (sb_phy),
		.sb_eeprom (sb_eeprom),
		.sb_d      (sb_wdata),
		.hw_ld     (1'b0),
		.hw_d      (32'h0000_0000),
		.q_ff      (q_phy)
	);

	spt_word #(
		.RST    (`SPT_RST_TX_MARGIN),
		.VALID  (`SPT_VLD_TX_MARGIN),
		.HOST_M (32'h0000_0000),
		.SB_M   (32'hffff_ffff),
		.EE_M   (32'hffff_ffff),
		.HW_M   (32'h0000_0000)
	) u_mrg (
		.clock     (clock),
		.nrst      (nrst),
		.host_we   (we_mrg),
		.host_be   (cfg_be),
		.host_d    (cfg_wdata),
		.sb_we     (sb_mrg),
		.sb_eeprom (sb_eeprom),
		.sb_d      (sb_wdata),
		.hw_ld     (1'b0),
		.hw_d      (32'h0000_0000),
		.q_ff      (q_mrg)
	);

	// Strap half is loaded from pins, never from sideband
	spt_word #(
		.RST    (OM_RST),
		.VALID  (`SPT_VLD_OPMODE),
		.HOST_M (32'h0000_0000),
		.SB_M   (`SPT_SB_OPMODE),
		.EE_M   (`SPT_SB_OPMODE),
		.HW_M   (`SPT_STRAP_OPMODE)
	) u_om (
		.clock     (clock),
		.nrst      (nrst),
		.host_we   (we_om),
		.host_be   (cfg_be),
		.host_d    (cfg_wdata),
		.sb_we     (sb_om),
		.sb_eeprom (sb_eeprom),
		.sb_d      (sb_wdata),
		.hw_ld     (~strap_done_ff),
		.hw_d      ({23'h000000, strap_mode}),
		.q_ff      (q_om)
	);

	// Straps are sampled once, in the first cycle after reset release
	always @(posedge clock)
	begin
		if (!nrst)
			strap_done_ff <= 1'b0;
		else
			strap_done_ff <= 1'b1;
	end

	// A downstream copy never governs upstream-only fields
	assign eff_tl  = IS_UPSTREAM ? q_tl : ((q_tl & ~`SPT_UP_TL_CTRL) | (up_tl_ctrl & `SPT_UP_TL_CTRL));
	assign eff_phy = IS_UPSTREAM ? q_phy :
		((q_phy & ~`SPT_UP_PHY_LANE_GLB) | (up_phy_lane_glb & `SPT_UP_PHY_LANE_GLB));
	assign eff_mrg = IS_UPSTREAM ? q_mrg : ((q_mrg & ~`SPT_UP_TX_MARGIN) | (up_tx_margin & `SPT_UP_TX_MARGIN));
	assign eff_om  = IS_UPSTREAM ? q_om : ((q_om & ~`SPT_UP_OPMODE) | (up_opmode & `SPT_UP_OPMODE));

	always @*
	begin
		case (cfg_addr)
			`SPT_OFS_TL_CTRL:      nxt_rdata = eff_tl;
			`SPT_OFS_PHY_LANE_GLB: nxt_rdata = eff_phy;
			`SPT_OFS_TX_MARGIN:    nxt_rdata = eff_mrg;
			`SPT_OFS_OPMODE:       nxt_rdata = eff_om;
			default:               nxt_rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge clock)
	begin
		if (!nrst)
		begin
			cfg_ack_ff                   <= 1'b0;
			cfg_rdata_ff                 <= 32'h0000_0000;
			tl_ctrl_ff                   <= 32'h0000_0000;
			phy_lane_glb_ff              <= 32'h0000_0000;
			tx_margin_ff                 <= 32'h0000_0000;
			opmode_ff                    <= 32'h0000_0000;
			ordering_rule_off_ff         <= 1'b0;
			port_off_ff                  <= 1'b0;
			rate_change_attempt_count_ff <= 2'h0;
			phy_err_retrain_off_ff       <= 1'b0;
			reset_source_sel_ff          <= 1'b0;
			lane_phy_mode_ff             <= 7'h00;
			phy_delta_ff                 <= 17'h00000;
			tx_margin_param_ff           <= 16'h0000;
			clock_buffer_ctrl_ff         <= 8'h00;
		end
		else
		begin
			cfg_ack_ff                   <= take;
			if (take & cfg_rd)
				cfg_rdata_ff <= nxt_rdata;
			tl_ctrl_ff                   <= eff_tl;
			phy_lane_glb_ff              <= eff_phy;
			tx_margin_ff                 <= eff_mrg;
			opmode_ff                    <= eff_om;
			ordering_rule_off_ff         <= eff_tl[`SPT_BIT_ORD_OFF];
			port_off_ff                  <= eff_tl[`SPT_BIT_PORT_OFF];
			rate_change_attempt_count_ff <= eff_tl[`SPT_POS_RATE_TRY +: 2];
			phy_err_retrain_off_ff       <= eff_tl[`SPT_POS_AUX_PHY];
			reset_source_sel_ff          <= IS_UPSTREAM ? eff_tl[`SPT_BIT_RSTSEL] : 1'b0;
			lane_phy_mode_ff             <= eff_phy[6:0];
			phy_delta_ff                 <= eff_phy[`SPT_POS_DELTA +: 17];
			tx_margin_param_ff           <= eff_mrg[15:0];
			clock_buffer_ctrl_ff         <= eff_om[`SPT_POS_CLKBUF +: 8];
		end
	end
endmodule // spt_regs

// ==== testbench/spt_regs_sva.sv ====
// Port-level checker for the port tuning register group
`timescale 1ns/10ps
module spt_regs_sva (
	input logic        clock,
	input logic        nrst,
	input logic        cfg_rd,
	input logic        cfg_wr,
	input logic        cfg_ack_ff,
	input logic        sb_wr,
	input logic        sb_eeprom,
	input logic        sb_load_busy,
	input logic [31:0] tl_ctrl_ff,
	input logic [31:0] phy_lane_glb_ff,
	input logic [31:0] opmode_ff,
	input logic        ordering_rule_off_ff,
	input logic        port_off_ff,
	input logic [1:0]  rate_change_attempt_count_ff,
	input logic        phy_err_retrain_off_ff,
	input logic [7:0]  clock_buffer_ctrl_ff
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	a_ack_one_cycle: assert property (cfg_ack_ff |=> !cfg_ack_ff)
		else $error("ack longer than one cycle");
	a_busy_holds_host: assert property (sb_load_busy |=> !cfg_ack_ff)
		else $error("ack while loading");
	a_request_acked: assert property ((cfg_rd || cfg_wr) && !sb_load_busy && !cfg_ack_ff |=> cfg_ack_ff)
		else $error("request not acked");
	a_ord_bit_map: assert property (ordering_rule_off_ff == tl_ctrl_ff[6])
		else $error("ordering flag mismatch");
	a_ord_change_source: assert property ($changed(ordering_rule_off_ff) |-> $past(cfg_ack_ff) || $past(sb_wr && sb_eeprom, 2))
		else $error("ordering flag changed by smbus");
	a_port_bit_map: assert property (port_off_ff == tl_ctrl_ff[10])
		else $error("port off mismatch");
	a_rate_field_map: assert property (rate_change_attempt_count_ff == tl_ctrl_ff[9:8])
		else $error("attempt count mismatch");
	a_retrain_bit_map: assert property (phy_err_retrain_off_ff == tl_ctrl_ff[16])
		else $error("retrain flag mismatch");
	a_clkbuf_field_map: assert property (clock_buffer_ctrl_ff == opmode_ff[23:16])
		else $error("clock buffer mismatch");
	a_reserved_zero: assert property (tl_ctrl_ff[15:13] == 3'h0 && !tl_ctrl_ff[30] && phy_lane_glb_ff[14:7] == 8'h00
		&& opmode_ff[31:28] == 4'h0 && opmode_ff[15:9] == 7'h00) else $error("reserved bits set");
	cover property (cfg_rd && cfg_ack_ff);
	cover property (sb_wr && sb_eeprom);
	cover property (sb_load_busy && cfg_rd);
endmodule // spt_regs_sva
bind spt_regs spt_regs_sva spt_regs_sva_inst (.clock, .nrst, .cfg_rd, .cfg_wr, .cfg_ack_ff, .sb_wr, .sb_eeprom,
	.sb_load_busy, .tl_ctrl_ff, .phy_lane_glb_ff, .opmode_ff, .ordering_rule_off_ff, .port_off_ff,
	.rate_change_attempt_count_ff, .phy_err_retrain_off_ff, .clock_buffer_ctrl_ff);

// ==== testbench/spt_regs_tb_top.sv ====
// Self-checking bench for the port tuning register group
`timescale 1ns/10ps
module spt_regs_tb_top;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic        cfg_rd = 1'b0, cfg_wr = 1'b0, sb_wr = 1'b0, sb_eeprom = 1'b0, sb_load_busy = 1'b0;
	logic [7:0]  cfg_addr = 8'h00, sb_addr = 8'h00;
	logic [3:0]  cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h0, sb_wdata = 32'h0;
	logic [8:0]  strap_mode = 9'h0a5;
	// All-ones upstream copy; the upstream port must ignore it
	logic [31:0] up_copy = 32'hffff_ffff;
	wire [15:0]  tx_margin_param_ff;
	wire [31:0]  tx_margin_ff;
	wire         cfg_ack_ff, ordering_rule_off_ff, port_off_ff, phy_err_retrain_off_ff, reset_source_sel_ff;
	wire [1:0]   rate_change_attempt_count_ff;
	wire [6:0]   lane_phy_mode_ff;
	wire [7:0]   clock_buffer_ctrl_ff;
	wire [16:0]  phy_delta_ff;
	wire [31:0]  cfg_rdata_ff;
	int          num_errors = 0, checks_done = 0, cycles = 0;

	spt_regs #(.IS_UPSTREAM(1), .SIX_PORT(1)) spt_regs_inst (.clock, .nrst, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be,
		.cfg_wdata, .cfg_ack_ff, .cfg_rdata_ff, .sb_wr, .sb_eeprom, .sb_addr, .sb_wdata, .sb_load_busy,
		.strap_mode, .up_tl_ctrl(up_copy), .up_phy_lane_glb(up_copy), .up_tx_margin(up_copy), .up_opmode(up_copy),
		.tl_ctrl_ff(), .phy_lane_glb_ff(), .tx_margin_ff, .opmode_ff(), .ordering_rule_off_ff, .port_off_ff,
		.rate_change_attempt_count_ff, .phy_err_retrain_off_ff, .reset_source_sel_ff, .lane_phy_mode_ff,
		.phy_delta_ff, .tx_margin_param_ff, .clock_buffer_ctrl_ff);

	always #4 clock = ~clock;

	// Whole run needs about a hundred cycles
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			num_errors++;
			print_verdict();
		end
	end

	task print_verdict();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// Request held until ack is sampled high, then dropped
	task acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
		@(posedge clock);
		cfg_rd <= !w;
		cfg_wr <= w;
		cfg_addr <= a;
		cfg_be <= b;
		cfg_wdata <= v;
		@(posedge clock);
		while (cfg_ack_ff !== 1'b1)
			@(posedge clock);
		cfg_rd <= 1'b0;
		cfg_wr <= 1'b0;
		if (!w)
			chk("rdata", v, cfg_rdata_ff);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 4'h0, e);
	endtask

	task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
		acc(1'b1, a, b, v);
	endtask

	task sbw(input logic e, input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		sb_wr <= 1'b1;
		sb_eeprom <= e;
		sb_addr <= a;
		sb_wdata <= v;
		@(posedge clock);
		sb_wr <= 1'b0;
	endtask

	initial
	begin
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		rd(8'h8c, 32'h0079_1894);
		rd(8'h90, 32'h0000_8000);
		rd(8'h94, 32'h0000_116b);
		rd(8'h98, 32'h007f_00a5);
		$display("reset value test done");
		wr(8'h8c, 4'hf, 32'hffff_ffff);
		rd(8'h8c, 32'h0079_18f4);
		chk("ordering", 32'h1, {31'h0, ordering_rule_off_ff});
		wr(8'h8c, 4'he, 32'h0);
		rd(8'h8c, 32'h0079_18f4);
		wr(8'h8c, 4'h1, 32'h0);
		wr(8'h98, 4'hf, 32'hffff_ffff);
		rd(8'h98, 32'h007f_00a5);
		wr(8'h80, 4'hf, 32'hffff_ffff);
		rd(8'h80, 32'h0);
		$display("host write test done");
		sbw(1'b0, 8'h8c, 32'hffff_ffff);
		rd(8'h8c, 32'hbfff_1fbf);
		chk("port_off", 32'h1, {31'h0, port_off_ff});
		chk("attempts", 32'h3, {30'h0, rate_change_attempt_count_ff});
		chk("retrain_off", 32'h1, {31'h0, phy_err_retrain_off_ff});
		sbw(1'b1, 8'h8c, 32'h0000_0040);
		rd(8'h8c, 32'h0000_0040);
		sbw(1'b0, 8'h90, 32'hffff_ffff);
		rd(8'h90, 32'hffff_807f);
		chk("lane_mode", 32'h7f, {25'h0, lane_phy_mode_ff});
		chk("delta", 32'h1ffff, {15'h0, phy_delta_ff});
		sbw(1'b1, 8'h98, 32'hffff_ffff);
		rd(8'h98, 32'h0fff_00a5);
		chk("clock_buf", 32'hff, {24'h0, clock_buffer_ctrl_ff});
		$display("sideband test done");
		@(posedge clock);
		sb_load_busy <= 1'b1;
		cfg_rd <= 1'b1;
		cfg_addr <= 8'h94;
		sbw(1'b1, 8'h94, 32'h0000_1234);
		repeat (3) @(posedge clock);
		chk("ack_busy", 32'h0, {31'h0, cfg_ack_ff});
		sb_load_busy <= 1'b0;
		rd(8'h94, 32'h0000_1234);
		chk("margin_word", 32'h0000_1234, tx_margin_ff);
		chk("margin_param", 32'h0000_1234, {16'h0, tx_margin_param_ff});
		$display("load hold-off test done");
		// Straps now match the six-port reset pattern and must be sampled again
		strap_mode <= 9'h022;
		nrst <= 1'b0;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		rd(8'h8c, 32'h0079_1894);
		chk("rst_sel", 32'h1, {31'h0, reset_source_sel_ff});
		rd(8'h98, 32'h007f_0022);
		$display("second reset test done");
		print_verdict();
	end
endmodule // spt_regs_tb_top
